// File: rf_cfg_host_model.sv
// ahb-lite host model that programs the rf configuration bank
`include "rf_cfg_params.svh"
`timescale 1ns/100ps
`default_nettype none

module rf_cfg_host_model
(
    // bus clock and answer
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // bus request
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    // bus idle at time zero
    initial
    begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // software keeps fixed fields at their required values
    function automatic logic [7:0] keep_fixed(input logic [7:0] idx,
                                              input logic [7:0] v);
        case (idx)
            `IDX_FACTORY_TRIM_A: return 8'h3F;
            `IDX_FACTORY_TRIM_B: return 8'h00;
            `IDX_RX_GAIN:        return {6'h1C, v[1:0]};
            `IDX_DRIVER_COND:    return {2'h0, v[5:0]};
            `IDX_DEC_BEHAVIOUR:  return {1'b0, v[6:5], 5'h08};
            default:             return v;
        endcase
    endfunction : keep_fixed

    // one single word transfer; read data taken at the data-phase edge
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [7:0] v, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, keep_fixed(idx, v)};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        hwdata <= ~hwdata; // released data shows no stale value
    endtask : xfer
endmodule : rf_cfg_host_model
`default_nettype wire

// File: rf_cfg_params.svh
// offsets, field positions, reset values and counts for the rf config bank
`ifndef RF_CFG_PARAMS_SVH
`define RF_CFG_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_DRIVER_COND    8'h30
`define IDX_MOD_PULSE_LEN  8'h31
`define IDX_FACTORY_TRIM_A 8'h13
`define IDX_RX_GAIN        8'h19
`define IDX_DEC_BEHAVIOUR  8'h32
`define IDX_CLOCK_SKEW     8'h33
`define IDX_DEC_THRESHOLD  8'h1C
`define IDX_FACTORY_TRIM_B 8'h1D
`define IDX_RX_STATUS      8'h34

// reset values
`define RST_DRIVER_COND    8'h3F
`define RST_MOD_PULSE_LEN  8'h13
`define RST_FACTORY_TRIM_A 8'h3F
`define RST_RX_GAIN        8'h73
`define RST_DEC_BEHAVIOUR  8'h08
`define RST_CLOCK_SKEW     8'h00
`define RST_DEC_THRESHOLD  8'hFF
`define RST_FACTORY_TRIM_B 8'h00

// field positions
`define COND_MSB           5
`define GAIN_MSB           1
`define MULTI_FRAME_BIT    6
`define MASK_COLL_BIT      5
`define FLOOR_MSB          7
`define FLOOR_LSB          4
`define COLL_MSB           3

// register slots and pulse counting
`define NUM_REGS           8
`define PULSE_CNT_W        10
`define GAIN_DB_20         6'h14
`define GAIN_DB_24         6'h18
`define GAIN_DB_31         6'h1F
`define GAIN_DB_35         6'h23

`endif

// File: rf_cfg_pkg.sv
// types shared by the rf transmitter and receiver configuration bank
package rf_cfg_pkg;

    // settings delivered to the transmitter
    typedef struct packed {
        logic [5:0] driver_conductance;
        logic [7:0] modulation_pulse_len;
        logic [7:0] tx_rx_clock_skew_value;
    } tx_cfg_s;

    // settings delivered to receiver and decoder
    typedef struct packed {
        logic [1:0] rx_gain;
        logic [5:0] rx_gain_db;
        logic       multi_frame_receive;
        logic       mask_after_collision;
        logic [3:0] signal_floor;
        logic [3:0] collision_threshold;
    } rx_cfg_s;

    // one decoded half-bit pair from the demodulator
    typedef struct packed {
        logic       valid;
        logic       bit_value;
        logic [3:0] strength;
        logic [3:0] weak_half;
    } dec_in_s;

    // decoder result
    typedef struct packed {
        logic valid;
        logic bit_value;
        logic collision;
    } dec_out_s;

endpackage : rf_cfg_pkg

// File: rf_tx_rx_config_regs.sv
// ahb-lite configuration bank with modulation timer and decoder gating
//
// Summary of operation
// - conductance bits 5-0 drive both antenna outputs; bits 7-6 kept zero.
// - a modulation pulse lasts two carrier periods times (length + 1).
// - first factory trim resets to 0x3F and software leaves it alone.
// - gain code 00/01/10/11 selects 20/24/31/35 dB receive gain.
// - gain register resets to 0x73, upper six bits kept at 011100.
// - without multi-frame the receiver stops after one frame.
// - with masking on, bits after a collision are forced to zero.
// - an eight-bit skew register sets tx to rx clock phase.
// - decoder ignores input weaker than the upper-nibble floor.
// - collision flagged only when weak half-bit reaches lower nibble.
// - threshold register resets to 0xFF.
// - second factory trim resets to 0x00 and stays zero.
`include "rf_cfg_params.svh"
`timescale 1ns/100ps
`default_nettype none

module rf_tx_rx_config_regs
(
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // transmitter side
    input  wire logic                 carrier_tick,
    input  wire logic                 mod_start,
    output logic                      mod_pulse,
    output rf_cfg_pkg::tx_cfg_s       tx_cfg,
    output logic [5:0]                antenna_out_a,
    output logic [5:0]                antenna_out_b,
    // receiver side
    input  wire logic                 rx_start,
    input  wire logic                 frame_done,
    input  wire rf_cfg_pkg::dec_in_s  dec_in,
    output logic                      rx_active,
    output rf_cfg_pkg::rx_cfg_s       rx_cfg,
    output rf_cfg_pkg::dec_out_s      dec_out
);
    import rf_cfg_pkg::*;

    logic [7:0]  regs_ff [`NUM_REGS];
    logic        wr_pend_ff;
    logic [2:0]  wr_slot_ff;
    logic [31:0] nxt_rdata;
    logic [7:0]  addr_idx;
    logic [2:0]  addr_slot;
    logic        addr_hit;
    logic        addr_ok;
    logic [`PULSE_CNT_W-1:0] pulse_cnt_ff;
    logic [`PULSE_CNT_W-1:0] pulse_len;
    logic        rx_active_ff;
    logic        coll_seen_ff;
    logic        weak_coll;
    logic        strong_enough;
    dec_out_s    dec_out_ff;
    logic [7:0]  status;
    logic [5:0]  gain_db_sel;

    // slot table: index, reset value
    function automatic logic [7:0] slot_idx(input logic [2:0] s);
        logic [7:0] r;
        unique case (s)
            3'h0: r = `IDX_DRIVER_COND;
            3'h1: r = `IDX_MOD_PULSE_LEN;
            3'h2: r = `IDX_FACTORY_TRIM_A;
            3'h3: r = `IDX_RX_GAIN;
            3'h4: r = `IDX_DEC_BEHAVIOUR;
            3'h5: r = `IDX_CLOCK_SKEW;
            3'h6: r = `IDX_DEC_THRESHOLD;
            3'h7: r = `IDX_FACTORY_TRIM_B;
        endcase
        return r;
    endfunction : slot_idx

    function automatic logic [7:0] slot_rst(input logic [2:0] s);
        logic [7:0] r;
        unique case (s)
            3'h0: r = `RST_DRIVER_COND;
            3'h1: r = `RST_MOD_PULSE_LEN;
            3'h2: r = `RST_FACTORY_TRIM_A;
            3'h3: r = `RST_RX_GAIN;
            3'h4: r = `RST_DEC_BEHAVIOUR;
            3'h5: r = `RST_CLOCK_SKEW;
            3'h6: r = `RST_DEC_THRESHOLD;
            3'h7: r = `RST_FACTORY_TRIM_B;
        endcase
        return r;
    endfunction : slot_rst

    // address decode of the address phase
    assign addr_idx = haddr[9:2];
    assign addr_ok  = hsel & htrans[1] & hready;
    always_comb
    begin
        addr_hit  = 1'b0;
        addr_slot = 3'h0;
        for (int i = 0; i < `NUM_REGS; i++)
        begin
            if (addr_idx == slot_idx(3'(i)))
            begin
                addr_hit  = 1'b1;
                addr_slot = 3'(i);
            end
        end
    end

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // write request held into the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_slot_ff <= 3'h0;
        end
        else
        begin
            wr_pend_ff <= addr_ok & hwrite & addr_hit;
            wr_slot_ff <= addr_slot;
        end
    end

    // register storage; changes only on write or reset
    for (genvar g = 0; g < `NUM_REGS; g++)
    begin : g_reg
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
                regs_ff[g] <= slot_rst(3'(g));
            else if (wr_pend_ff && wr_slot_ff == 3'(g))
                regs_ff[g] <= hwdata[7:0];
        end
    end

    // status word: receiver activity and collision memory
    assign status = {6'h00, coll_seen_ff, rx_active_ff};

    // read data sampled at the address phase
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        if (addr_idx == `IDX_RX_STATUS)
            nxt_rdata = {24'h00_0000, status};
        else if (addr_hit && wr_pend_ff && wr_slot_ff == addr_slot)
            nxt_rdata = {24'h00_0000, hwdata[7:0]}; // write in flight
        else if (addr_hit)
            nxt_rdata = {24'h00_0000, regs_ff[addr_slot]};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (addr_ok && !hwrite)
            hrdata <= nxt_rdata;
    end

    // static settings to the transmitter
    assign tx_cfg.driver_conductance     = regs_ff[0][`COND_MSB:0];
    assign tx_cfg.modulation_pulse_len   = regs_ff[1];
    assign tx_cfg.tx_rx_clock_skew_value = regs_ff[5];
    assign antenna_out_a = regs_ff[0][`COND_MSB:0];
    assign antenna_out_b = regs_ff[0][`COND_MSB:0];

    // static settings to the receiver and decoder
    assign rx_cfg.rx_gain = regs_ff[3][`GAIN_MSB:0];
    always_comb
    begin
        unique case (regs_ff[3][`GAIN_MSB:0])
            2'h0: gain_db_sel = `GAIN_DB_20;
            2'h1: gain_db_sel = `GAIN_DB_24;
            2'h2: gain_db_sel = `GAIN_DB_31;
            2'h3: gain_db_sel = `GAIN_DB_35;
        endcase
    end
    assign rx_cfg.rx_gain_db = gain_db_sel;
    assign rx_cfg.multi_frame_receive  = regs_ff[4][`MULTI_FRAME_BIT];
    assign rx_cfg.mask_after_collision = regs_ff[4][`MASK_COLL_BIT];
    assign rx_cfg.signal_floor =
        regs_ff[6][`FLOOR_MSB:`FLOOR_LSB];
    assign rx_cfg.collision_threshold = regs_ff[6][`COLL_MSB:0];

    // modulation pulse timer counts carrier ticks
    assign pulse_len = {1'b0, regs_ff[1], 1'b0} + `PULSE_CNT_W'(2);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pulse_cnt_ff <= '0;
        else if (pulse_cnt_ff == '0 && mod_start)
            pulse_cnt_ff <= pulse_len;
        else if (pulse_cnt_ff != '0 && carrier_tick)
            pulse_cnt_ff <= pulse_cnt_ff - `PULSE_CNT_W'(1);
    end
    assign mod_pulse = (pulse_cnt_ff != '0);

    // receiver activity over frames
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rx_active_ff <= 1'b0;
        else if (rx_start)
            rx_active_ff <= 1'b1;
        else if (frame_done && !rx_cfg.multi_frame_receive)
            rx_active_ff <= 1'b0;
    end
    assign rx_active = rx_active_ff;

    // decoder thresholds
    assign strong_enough = dec_in.strength >= rx_cfg.signal_floor;
    assign weak_coll = dec_in.weak_half >= rx_cfg.collision_threshold;

    // collision memory within one reception
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            coll_seen_ff <= 1'b0;
        else if (dec_in.valid && rx_active_ff && strong_enough && weak_coll)
            coll_seen_ff <= 1'b1; // (a collision beats a restart)
        else if (rx_start)
            coll_seen_ff <= 1'b0;
    end

    // decoded bit, masked after a collision
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            dec_out_ff <= '0;
        else
        begin
            dec_out_ff.valid <= dec_in.valid & rx_active_ff & strong_enough;
            dec_out_ff.collision <= strong_enough & weak_coll;
            dec_out_ff.bit_value <= dec_in.bit_value &
                ~(rx_cfg.mask_after_collision & coll_seen_ff);
        end
    end
    assign dec_out = dec_out_ff;

    // checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_cond_to_pins: assert property (
        antenna_out_a == regs_ff[0][5:0] && antenna_out_b == antenna_out_a)
        else $error("conductance not on both driver outputs");

    a_pulse_start_len: assert property (
        (pulse_cnt_ff == '0 && mod_start) |=>
            pulse_cnt_ff == {1'b0, $past(regs_ff[1]), 1'b0} + 10'h002)
        else $error("modulation pulse length wrong");

    a_pulse_tick_down: assert property (
        (pulse_cnt_ff != '0 && carrier_tick) |=>
            pulse_cnt_ff == $past(pulse_cnt_ff) - 10'h001)
        else $error("modulation counter missed a carrier tick");

    a_gain_decode: assert property (
        regs_ff[3][1:0] == 2'h2 |-> rx_cfg.rx_gain_db == 6'h1F)
        else $error("gain code 10 not 31 dB");

    a_rx_single_stop: assert property (
        (rx_active_ff && frame_done && !rx_start && !regs_ff[4][6])
            |=> !rx_active)
        else $error("receiver stayed on after single frame");

    a_rx_multi_hold: assert property (
        (rx_active_ff && regs_ff[4][6]) |=> rx_active)
        else $error("receiver stopped in multi-frame mode");

    a_mask_zero: assert property (
        (coll_seen_ff && regs_ff[4][5] && !rx_start) |=> !dec_out.bit_value)
        else $error("bit after collision not masked");

    a_coll_gate: assert property (
        (dec_in.weak_half < regs_ff[6][3:0]) |=> !dec_out.collision)
        else $error("collision flagged below threshold");

    a_floor_gate: assert property (
        (dec_in.strength < regs_ff[6][7:4]) |=> !dec_out.valid)
        else $error("weak input evaluated");

    a_static_cfg: assert property (
        !wr_pend_ff |=> $stable(regs_ff[6]) && $stable(regs_ff[3]))
        else $error("setting changed without a write");

    a_skew_out: assert property (
        (wr_pend_ff && wr_slot_ff == 3'h5) |=>
            tx_cfg.tx_rx_clock_skew_value == $past(hwdata[7:0]))
        else $error("skew write not presented");

endmodule : rf_tx_rx_config_regs

`default_nettype wire

// File: test_rf_tx_rx_config_regs.sv
// self-checking bench for the rf transmitter and receiver config bank
`include "rf_cfg_params.svh"
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end

module test_rf_tx_rx_config_regs;
    import rf_cfg_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        carrier_tick, mod_start, mod_pulse;
    logic        rx_start, frame_done, rx_active;
    logic [5:0]  antenna_out_a, antenna_out_b;
    tx_cfg_s     tx_cfg;
    rx_cfg_s     rx_cfg;
    dec_in_s     dec_in;
    dec_out_s    dec_out, o;
    logic [7:0]  v, c, f, t;
    int          error_cnt, n_compared, cyc, ticks;
    logic [7:0]  idx_tab [8] = '{`IDX_DRIVER_COND, `IDX_MOD_PULSE_LEN,
        `IDX_FACTORY_TRIM_A, `IDX_RX_GAIN, `IDX_DEC_BEHAVIOUR,
        `IDX_CLOCK_SKEW, `IDX_DEC_THRESHOLD, `IDX_FACTORY_TRIM_B};
    logic [7:0]  rst_tab [8] = '{`RST_DRIVER_COND, `RST_MOD_PULSE_LEN,
        8'h3F, 8'h73, `RST_DEC_BEHAVIOUR, `RST_CLOCK_SKEW, 8'hFF, 8'h00};

    rf_tx_rx_config_regs rf_tx_rx_config_regs_inst (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .carrier_tick(carrier_tick), .mod_start(mod_start),
        .mod_pulse(mod_pulse), .tx_cfg(tx_cfg), .antenna_out_a(antenna_out_a),
        .antenna_out_b(antenna_out_b), .rx_start(rx_start),
        .frame_done(frame_done), .dec_in(dec_in), .rx_active(rx_active),
        .rx_cfg(rx_cfg), .dec_out(dec_out));

    rf_cfg_host_model rf_cfg_host_model_inst (.hclk(hclk),
        .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // expected receive gain in dB for each gain code
    function automatic logic [5:0] gain_db(input int code);
        case (code)
            0: return 6'h14;
            1: return 6'h18;
            2: return 6'h1F;
            default: return 6'h23;
        endcase
    endfunction : gain_db

    // register write, outputs settled on return
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        rf_cfg_host_model_inst.xfer(1'b1, idx, val, rd);
        @(posedge hclk);
    endtask : wr

    // register read compared against an expected byte
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        rf_cfg_host_model_inst.xfer(1'b0, idx, 8'h00, rd);
        `CHK(rd, {24'h0, exp})
    endtask : rdchk

    // one decoder input, result captured in the cycle after it stands
    task automatic dec(input logic [3:0] s, input logic [3:0] w);
        @(posedge hclk);
        dec_in <= '{1'b1, 1'b1, s, w};
        @(posedge hclk);
        dec_in <= '0;
        #1 o = dec_out;
    endtask : dec

    // one-cycle pulse on receiver start or frame end
    task automatic strobe(input logic start);
        @(posedge hclk);
        rx_start   <= start;
        frame_done <= !start;
        @(posedge hclk);
        rx_start   <= 1'b0;
        frame_done <= 1'b0;
        @(posedge hclk);
    endtask : strobe

    // verdict and end of run
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // free-running clock
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // hang guard
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    // main sequence
    initial
    begin
        {hresetn, carrier_tick, mod_start, rx_start, frame_done} = '0;
        dec_in = '0;
        void'($urandom(51144));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 8; i++)
            rdchk(idx_tab[i], rst_tab[i]);
        `CHK(rx_cfg.rx_gain_db, 6'h23)
        rdchk(8'h00, 8'h00);
        `CHK(hresp, 1'b0)
        `CHK(hreadyout, 1'b1)
        wr(`IDX_FACTORY_TRIM_A, 8'h00);
        rdchk(`IDX_FACTORY_TRIM_A, 8'h3F);
        for (int i = 0; i < 8; i++)
        begin
            c = 8'($urandom);
            wr(`IDX_DRIVER_COND, c);
            `CHK({antenna_out_a, antenna_out_b}, {2{c[5:0]}})
            `CHK(tx_cfg.driver_conductance, c[5:0])
            rdchk(`IDX_DRIVER_COND, {2'h0, c[5:0]});
            v = 8'($urandom);
            wr(`IDX_CLOCK_SKEW, v);
            `CHK(tx_cfg.tx_rx_clock_skew_value, v)
            v = 8'($urandom);
            wr(`IDX_DEC_THRESHOLD, v);
            `CHK({rx_cfg.signal_floor, rx_cfg.collision_threshold}, v)
            wr(`IDX_RX_GAIN, i[7:0]);
            `CHK(rx_cfg.rx_gain_db, gain_db(i % 4))
            `CHK(rx_cfg.rx_gain, i[1:0])
            rdchk(`IDX_RX_GAIN, {6'h1C, i[1:0]});
        end
        // modulation pulses: shortest length, then random ones
        for (int p = 0; p < 4; p++)
        begin
            v = (p == 0) ? 8'h00 : 8'h07 & 8'($urandom);
            wr(`IDX_MOD_PULSE_LEN, v);
            `CHK(tx_cfg.modulation_pulse_len, v)
            @(posedge hclk);
            mod_start <= 1'b1;
            @(posedge hclk);
            mod_start <= 1'b0;
            ticks = 0;
            for (int k = 0; k < 100; k++)
            begin
                @(posedge hclk);
                if (mod_pulse !== 1'b1)
                    break;
                if (carrier_tick)
                    ticks++;
                carrier_tick <= ~carrier_tick;
            end
            carrier_tick <= 1'b0;
            `CHK(ticks, 2 * (v + 1))
        end
        // decoder thresholds, masking and frame handling
        f = 8'(1 + $urandom % 8);
        t = 8'(1 + $urandom % 15);
        wr(`IDX_DEC_THRESHOLD, {f[3:0], t[3:0]});
        for (int m = 0; m < 2; m++)
        begin
            wr(`IDX_DEC_BEHAVIOUR, {1'b0, m[0], 1'b1, 5'h08});
            `CHK(rx_cfg.multi_frame_receive, m[0])
            `CHK(rx_cfg.mask_after_collision, 1'b1)
            strobe(1'b1);
            `CHK(rx_active, 1'b1)
            dec(f[3:0] - 4'h1, 4'h0);
            `CHK(o.valid, 1'b0)
            dec(f[3:0], t[3:0] - 4'h1);
            `CHK(o, 3'h6)
            dec(f[3:0], t[3:0]);
            `CHK(o.collision, 1'b1)
            dec(f[3:0], 4'h0);
            `CHK(o.bit_value, 1'b0)
            strobe(1'b0);
            `CHK(rx_active, m[0])
        end
        // status: still receiving in multi-frame mode, collision remembered
        rdchk(`IDX_RX_STATUS, 8'h03);
        `CHK(antenna_out_a, c[5:0])
        // reset in mid-run brings every register back
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        `CHK(rx_active, 1'b0)
        for (int i = 0; i < 8; i++)
            rdchk(idx_tab[i], rst_tab[i]);
        complete_run();
    end
endmodule : test_rf_tx_rx_config_regs
`default_nettype wire
